// file: verilog/mief_top.sv
// interrupt request flags, enables and sub-source flags behind an ahb-lite slave
`default_nettype none
`include "mief_map.svh"

module mief_top
  import mief_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        ARST_N_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire logic        TIMER0_OVERFLOW_I,
  input  wire logic        TIMER1_OVERFLOW_I,
  input  wire logic        TIMER0_VECTOR_ACK_I,
  input  wire logic        TIMER1_VECTOR_ACK_I,
  input  wire logic [6:0]  EXT_VECTOR_ACK_I,
  input  wire logic        SERIAL1_REQ_I,
  input  wire logic        DIO_HIGH_PRIO_I,
  input  wire logic        DIO_LOW_PRIO_I,
  input  wire logic        FLASH_COLLISION_A_I,
  input  wire logic        FLASH_COLLISION_B_I,
  input  wire logic        ENGINE_BUSY_I,
  input  wire logic        LOCK_OK_I,
  input  wire logic        EEPROM_BUSY_I,
  input  wire logic        ENGINE_TRANSFER_EVENT_I,
  input  wire logic        SECONDS_TICK_I,
  input  wire logic        TIMED_WAKE_I,
  input  wire logic        PUSH_BUTTON_I,
  output logic      [9:0]  IRQ_REQ_O
);

  mief_state_s cur_r;
  mief_state_s cur_nxt;

  // edge history slots in prev
  localparam int P_DIO0 = 0;
  localparam int P_DIO1 = 1;
  localparam int P_INT2 = 2;
  localparam int P_INT3 = 3;
  localparam int P_INT4 = 4;
  localparam int P_INT5 = 5;
  localparam int P_XFER = 6;
  localparam int P_SEC  = 7;
  localparam int P_LOCK = 8;
  localparam int P_INT6 = 9;

  logic [9:0]  line;
  logic        addr_ok;
  logic        wr_hit;
  logic [7:0]  wdat;
  logic [7:0]  rd_byte;
  logic        int2_src;
  logic        int3_src;
  logic        int4_src;
  logic        int6_src;
  logic [6:0]  ext_set;

  // word address decode, low two bits dropped
  function automatic logic [7:0] read_reg(input mief_state_s s, input logic [15:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      `MIEF_IDX_TIMER_AND_EXT_CONTROL:  v = s.timer_and_ext_control;
      `MIEF_IDX_INTERRUPT_ENABLE_0:  v = s.interrupt_enable_0;
      `MIEF_IDX_INTERRUPT_ENABLE_1:  v = s.interrupt_enable_1;
      `MIEF_IDX_INTERRUPT_ENABLE_2:  v = s.interrupt_enable_2;
      `MIEF_IDX_TIMER2_POLARITY_CONTROL: v = s.timer2_polarity_control;
      `MIEF_IDX_EXT_EDGE_REQUEST: v = s.ext_edge_request & `MIEF_IR_MASK;
      `MIEF_IDX_FLAGS: v = s.flags;
      `MIEF_IDX_XT_EN: v = s.xt_en;
      `MIEF_IDX_CL_EN: v = s.cl_en;
      default:         v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    int2_src = cur_r.cl_en[`MIEF_CL_COL] &
               (cur_r.flags[`MIEF_FL_COLA] | cur_r.flags[`MIEF_FL_COLB]);
    int3_src = ENGINE_BUSY_I;
    int4_src = (cur_r.cl_en[`MIEF_CL_LGAIN] & cur_r.flags[`MIEF_FL_LGAIN]) |
               (cur_r.cl_en[`MIEF_CL_LLOSS] & cur_r.flags[`MIEF_FL_LLOSS]);
    // int6 is the or of enabled transfer and tick flags
    int6_src = (cur_r.xt_en[`MIEF_XT_XFER] & cur_r.flags[`MIEF_FL_XFER]) |
               (cur_r.xt_en[`MIEF_XT_SEC] & cur_r.flags[`MIEF_FL_SEC]);
    line          = 10'h000;
    line[P_DIO0]  = DIO_HIGH_PRIO_I;
    line[P_DIO1]  = DIO_LOW_PRIO_I;
    line[P_INT2]  = int2_src;
    line[P_INT3]  = int3_src;
    line[P_INT4]  = int4_src;
    // inverted sources, rising detector sees source falling edge
    line[P_INT5]  = ~EEPROM_BUSY_I;
    line[P_XFER]  = ~ENGINE_TRANSFER_EVENT_I;
    line[P_SEC]   = ~SECONDS_TICK_I;
    line[P_LOCK]  = LOCK_OK_I;
    line[P_INT6]  = int6_src;
  end

  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.prev = line;
    wdat = HWDATA_I[7:0];
    wr_hit = (cur_r.bus == MIEF_BUS_WR);
    rd_byte = read_reg(cur_r, cur_r.addr);
    addr_ok = HSEL_I & HTRANS_I[1] & HREADY_I;
    ext_set = 7'h00;

    // software writes first, hardware sets applied after so sets win
    if (wr_hit) begin
      case (cur_r.addr)
        `MIEF_IDX_TIMER_AND_EXT_CONTROL:  cur_nxt.timer_and_ext_control = wdat;
        `MIEF_IDX_INTERRUPT_ENABLE_0:  cur_nxt.interrupt_enable_0 = wdat;
        `MIEF_IDX_INTERRUPT_ENABLE_1:  cur_nxt.interrupt_enable_1 = wdat;
        `MIEF_IDX_INTERRUPT_ENABLE_2:  cur_nxt.interrupt_enable_2 = wdat;
        `MIEF_IDX_TIMER2_POLARITY_CONTROL: cur_nxt.timer2_polarity_control = wdat;
        `MIEF_IDX_EXT_EDGE_REQUEST: cur_nxt.ext_edge_request = wdat & `MIEF_IR_MASK;
        // only written zeros clear, ones leave flags alone
        `MIEF_IDX_FLAGS: cur_nxt.flags = cur_r.flags & wdat;
        `MIEF_IDX_XT_EN: cur_nxt.xt_en = wdat;
        `MIEF_IDX_CL_EN: cur_nxt.cl_en = wdat;
        default: begin
        end
      endcase
    end

    // timer and external flags cleared on service entry
    if (TIMER0_VECTOR_ACK_I) begin
      cur_nxt.timer_and_ext_control[`MIEF_TC_TF0] = 1'b0;
    end
    if (TIMER1_VECTOR_ACK_I) begin
      cur_nxt.timer_and_ext_control[`MIEF_TC_TF1] = 1'b0;
    end
    if (EXT_VECTOR_ACK_I[0]) begin
      cur_nxt.timer_and_ext_control[`MIEF_TC_IE0] = 1'b0;
    end
    if (EXT_VECTOR_ACK_I[1]) begin
      cur_nxt.timer_and_ext_control[`MIEF_TC_IE1] = 1'b0;
    end
    for (int k = 0; k < 5; k++) begin
      if (EXT_VECTOR_ACK_I[k+2]) begin
        cur_nxt.ext_edge_request[`MIEF_IR_EXT2+k] = 1'b0;
      end
    end

    if (TIMER0_OVERFLOW_I) begin
      cur_nxt.timer_and_ext_control[`MIEF_TC_TF0] = 1'b1;
    end
    if (TIMER1_OVERFLOW_I) begin
      cur_nxt.timer_and_ext_control[`MIEF_TC_TF1] = 1'b1;
    end

    // type bit: 1 falling edge, 0 low level on the dio route
    // dio routes feed ext0 and ext1
    if (cur_r.timer_and_ext_control[`MIEF_TC_IT0]) begin
      ext_set[0] = cur_r.prev[P_DIO0] & ~line[P_DIO0];
    end else begin
      ext_set[0] = ~line[P_DIO0];
    end
    if (cur_r.timer_and_ext_control[`MIEF_TC_IT1]) begin
      ext_set[1] = cur_r.prev[P_DIO1] & ~line[P_DIO1];
    end else begin
      ext_set[1] = ~line[P_DIO1];
    end
    // programmable polarity on int2 and int3
    if (cur_r.timer2_polarity_control[`MIEF_T2_I2POL]) begin
      ext_set[2] = ~cur_r.prev[P_INT2] & line[P_INT2];
    end else begin
      ext_set[2] = cur_r.prev[P_INT2] & ~line[P_INT2];
    end
    if (cur_r.timer2_polarity_control[`MIEF_T2_I3POL]) begin
      ext_set[3] = ~cur_r.prev[P_INT3] & line[P_INT3];
    end else begin
      ext_set[3] = cur_r.prev[P_INT3] & ~line[P_INT3];
    end
    // rising-edge detectors of the core for int4 and int5
    ext_set[4] = ~cur_r.prev[P_INT4] & line[P_INT4];
    ext_set[5] = ~cur_r.prev[P_INT5] & line[P_INT5];
    // falling edge of the combined tick and transfer request
    ext_set[6] = cur_r.prev[P_INT6] & ~line[P_INT6];

    if (ext_set[0]) begin
      cur_nxt.timer_and_ext_control[`MIEF_TC_IE0] = 1'b1;
    end
    if (ext_set[1]) begin
      cur_nxt.timer_and_ext_control[`MIEF_TC_IE1] = 1'b1;
    end
    // edge flags land in bits 1..5
    for (int k = 0; k < 5; k++) begin
      if (ext_set[k+2]) begin
        cur_nxt.ext_edge_request[`MIEF_IR_EXT2+k] = 1'b1;
      end
    end

    // sub-source flags set regardless of their enables
    // transfer and tick flags on source falling edge
    if (~cur_r.prev[P_XFER] & line[P_XFER]) begin
      cur_nxt.flags[`MIEF_FL_XFER] = 1'b1;
    end
    if (~cur_r.prev[P_SEC] & line[P_SEC]) begin
      cur_nxt.flags[`MIEF_FL_SEC] = 1'b1;
    end
    // collision events are pulses from the flash arbiter
    if (FLASH_COLLISION_A_I) begin
      cur_nxt.flags[`MIEF_FL_COLA] = 1'b1;
    end
    if (FLASH_COLLISION_B_I) begin
      cur_nxt.flags[`MIEF_FL_COLB] = 1'b1;
    end
    if (~cur_r.prev[P_LOCK] & line[P_LOCK]) begin
      cur_nxt.flags[`MIEF_FL_LGAIN] = 1'b1;
    end
    if (cur_r.prev[P_LOCK] & ~line[P_LOCK]) begin
      cur_nxt.flags[`MIEF_FL_LLOSS] = 1'b1;
    end
    // wake cause flags, button sets even while awake
    if (TIMED_WAKE_I) begin
      cur_nxt.flags[`MIEF_FL_WAKE] = 1'b1;
    end
    if (PUSH_BUTTON_I) begin
      cur_nxt.flags[`MIEF_FL_BTN] = 1'b1;
    end

    // request outputs, global enable over all
    // per-source enables
    cur_nxt.req = 10'h000;
    cur_nxt.req[MIEF_Q_EXT0] = cur_nxt.timer_and_ext_control[`MIEF_TC_IE0] & cur_nxt.interrupt_enable_0[`MIEF_IE0_EX0];
    cur_nxt.req[MIEF_Q_TF0]  = cur_nxt.timer_and_ext_control[`MIEF_TC_TF0] & cur_nxt.interrupt_enable_0[`MIEF_IE0_ET0];
    cur_nxt.req[MIEF_Q_EXT1] = cur_nxt.timer_and_ext_control[`MIEF_TC_IE1] & cur_nxt.interrupt_enable_0[`MIEF_IE0_EX1];
    cur_nxt.req[MIEF_Q_TF1]  = cur_nxt.timer_and_ext_control[`MIEF_TC_TF1] & cur_nxt.interrupt_enable_0[`MIEF_IE0_ET1];
    for (int k = 0; k < 5; k++) begin
      cur_nxt.req[4+k] = cur_nxt.ext_edge_request[`MIEF_IR_EXT2+k] & cur_nxt.interrupt_enable_1[`MIEF_IR_EXT2+k];
    end
    // serial 1 blocked while its enable is zero
    cur_nxt.req[MIEF_Q_SER1] = SERIAL1_REQ_I & cur_nxt.interrupt_enable_2[`MIEF_IE2_ES1];
    if (!cur_nxt.interrupt_enable_0[`MIEF_IE0_EAL]) begin
      cur_nxt.req = 10'h000;
    end

    // bus: write has no wait; read takes one wait so earlier writes are seen
    case (cur_r.bus)
      MIEF_BUS_RD: begin
        cur_nxt.rdata = {24'h000000, rd_byte};
        cur_nxt.ready = 1'b1;
        cur_nxt.bus   = MIEF_BUS_IDLE;
      end
      MIEF_BUS_WR,
      MIEF_BUS_IDLE: begin
        cur_nxt.bus = MIEF_BUS_IDLE;
        if (addr_ok) begin
          cur_nxt.addr = HADDR_I[17:2];
          if (HWRITE_I) begin
            cur_nxt.bus = MIEF_BUS_WR;
          end else begin
            cur_nxt.bus   = MIEF_BUS_RD;
            cur_nxt.ready = 1'b0;
          end
        end
      end
      default: begin
        cur_nxt.bus   = MIEF_BUS_IDLE;
        cur_nxt.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cur_r       <= '0;
      cur_r.ready <= 1'b1;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign HRDATA_O    = cur_r.rdata;
  assign HREADYOUT_O = cur_r.ready;
  // always okay
  assign HRESP_O     = 1'b0;
  assign IRQ_REQ_O   = cur_r.req;

endmodule
`default_nettype wire

// file: verilog/mief_map.svh
// register offsets, field positions and reset values of the interrupt flag block
`ifndef MIEF_MAP_SVH
`define MIEF_MAP_SVH

// printed offsets are register indexes; byte address is four times the index
`define MIEF_IDX_TIMER_AND_EXT_CONTROL        16'h0088
`define MIEF_IDX_INTERRUPT_ENABLE_0        16'h00a8
`define MIEF_IDX_INTERRUPT_ENABLE_1        16'h00b8
`define MIEF_IDX_EXT_EDGE_REQUEST       16'h00c0
`define MIEF_IDX_FLAGS       16'h00e8
`define MIEF_IDX_XT_EN       16'h2002
`define MIEF_IDX_CL_EN       16'h2007
`define MIEF_IDX_INTERRUPT_ENABLE_2        16'h009a
`define MIEF_IDX_TIMER2_POLARITY_CONTROL       16'h00c8

// timer_and_ext_control fields
`define MIEF_TC_TF1          7
`define MIEF_TC_TF0          5
`define MIEF_TC_IE1          3
`define MIEF_TC_IT1          2
`define MIEF_TC_IE0          1
`define MIEF_TC_IT0          0

// interrupt_enable_0 fields
`define MIEF_IE0_EAL         7
`define MIEF_IE0_ET1         3
`define MIEF_IE0_EX1         2
`define MIEF_IE0_ET0         1
`define MIEF_IE0_EX0         0

// interrupt_enable_2 field
`define MIEF_IE2_ES1         0

// timer2_polarity_control fields
`define MIEF_T2_I3POL        6
`define MIEF_T2_I2POL        5

// ext_edge_request: ext2..ext6 at bits 1..5
`define MIEF_IR_EXT2         1
`define MIEF_IR_MASK         8'h3e

// subsource_flags fields
`define MIEF_FL_XFER         0
`define MIEF_FL_SEC          1
`define MIEF_FL_COLB         2
`define MIEF_FL_COLA         3
`define MIEF_FL_BTN          4
`define MIEF_FL_WAKE         5
`define MIEF_FL_LGAIN        6
`define MIEF_FL_LLOSS        7

// enable register fields
`define MIEF_XT_XFER         0
`define MIEF_XT_SEC          1
`define MIEF_CL_COL          4
`define MIEF_CL_LLOSS        5
`define MIEF_CL_LGAIN        6

// reset values
`define MIEF_RST_BYTE        8'h00

`endif

// file: verilog/mief_pkg.sv
// types of the interrupt flag block
`default_nettype none
package mief_pkg;

  typedef logic [7:0] mief_byte_t;

  // request vector order at the core side
  typedef enum logic [3:0] {
    MIEF_Q_EXT0   = 4'h0,
    MIEF_Q_TF0    = 4'h1,
    MIEF_Q_EXT1   = 4'h2,
    MIEF_Q_TF1    = 4'h3,
    MIEF_Q_EXT2   = 4'h4,
    MIEF_Q_EXT3   = 4'h5,
    MIEF_Q_EXT4   = 4'h6,
    MIEF_Q_EXT5   = 4'h7,
    MIEF_Q_EXT6   = 4'h8,
    MIEF_Q_SER1   = 4'h9
  } mief_req_e;

  typedef enum logic [1:0] {
    MIEF_BUS_IDLE = 2'b00,
    MIEF_BUS_WR   = 2'b01,
    MIEF_BUS_RD   = 2'b10
  } mief_bus_e;

  typedef struct packed {
    mief_byte_t  timer_and_ext_control;
    mief_byte_t  interrupt_enable_0;
    mief_byte_t  interrupt_enable_1;
    mief_byte_t  interrupt_enable_2;
    mief_byte_t  timer2_polarity_control;
    mief_byte_t  ext_edge_request;
    mief_byte_t  flags;
    mief_byte_t  xt_en;
    mief_byte_t  cl_en;
    logic [9:0]  prev;
    mief_bus_e   bus;
    logic [15:0] addr;
    logic [31:0] rdata;
    logic        ready;
    logic [9:0]  req;
  } mief_state_s;

endpackage
`default_nettype wire

// file: verif/mief_top_chk.sv
// port assertions of the interrupt flag block
`default_nettype none
module mief_top_chk (
  input wire logic       CLK_I,
  input wire logic       ARST_N_I,
  input wire logic       HSEL_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic       HWRITE_I,
  input wire logic       HREADY_I,
  input wire logic       HREADYOUT_O,
  input wire logic       HRESP_O,
  input wire logic       TIMER0_OVERFLOW_I,
  input wire logic       TIMER1_OVERFLOW_I,
  input wire logic       TIMER0_VECTOR_ACK_I,
  input wire logic       TIMER1_VECTOR_ACK_I,
  input wire logic [6:0] EXT_VECTOR_ACK_I,
  input wire logic       DIO_HIGH_PRIO_I,
  input wire logic       SERIAL1_REQ_I,
  input wire logic [9:0] IRQ_REQ_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  sequence rd_taken;
    HSEL_I && HTRANS_I[1] && HREADY_I && !HWRITE_I;
  endsequence
  sequence rd_answer;
    !HREADYOUT_O ##1 HREADYOUT_O;
  endsequence
  a_resp_always_okay: assert property (HRESP_O == 1'b0)
    else $error("response not okay");
  a_read_one_wait: assert property (rd_taken |=> rd_answer)
    else $error("read wait not one cycle");
  a_write_no_wait: assert property (HSEL_I && HTRANS_I[1] && HREADY_I && HWRITE_I |=> HREADYOUT_O)
    else $error("write stalled");
  a_ready_low_cause: assert property ($fell(HREADYOUT_O) |-> $past(HTRANS_I[1] && !HWRITE_I))
    else $error("wait state without read");
  a_t0_ack_clear: assert property (TIMER0_VECTOR_ACK_I && !TIMER0_OVERFLOW_I |=> !IRQ_REQ_O[1])
    else $error("timer 0 request kept after ack");
  a_t1_ack_clear: assert property (TIMER1_VECTOR_ACK_I && !TIMER1_OVERFLOW_I |=> !IRQ_REQ_O[3])
    else $error("timer 1 request kept after ack");
  a_ext0_ack_clear: assert property (EXT_VECTOR_ACK_I[0] && DIO_HIGH_PRIO_I |=> !IRQ_REQ_O[0])
    else $error("ext0 request kept after ack");
  a_serial_gated: assert property (IRQ_REQ_O[9] |-> $past(SERIAL1_REQ_I))
    else $error("serial request without source");
endmodule
bind mief_top mief_top_chk u_chk (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .HSEL_I(HSEL_I),
  .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HREADYOUT_O(HREADYOUT_O),
  .HRESP_O(HRESP_O), .TIMER0_OVERFLOW_I(TIMER0_OVERFLOW_I), .TIMER1_OVERFLOW_I(TIMER1_OVERFLOW_I),
  .TIMER0_VECTOR_ACK_I(TIMER0_VECTOR_ACK_I), .TIMER1_VECTOR_ACK_I(TIMER1_VECTOR_ACK_I),
  .EXT_VECTOR_ACK_I(EXT_VECTOR_ACK_I), .DIO_HIGH_PRIO_I(DIO_HIGH_PRIO_I),
  .SERIAL1_REQ_I(SERIAL1_REQ_I), .IRQ_REQ_O(IRQ_REQ_O));
`default_nettype wire

// file: verif/mief_core_model.sv
// core side model: vectors to every pending request except serial 1 while allowed
`default_nettype none
module mief_core_model (
  input  wire logic       clk_i,
  input  wire logic       ack_en_i,
  input  wire logic [9:0] irq_i,
  output var  logic       t0_ack_o,
  output var  logic       t1_ack_o,
  output var  logic [6:0] ext_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    t0_ack_o = 1'b0;
    t1_ack_o = 1'b0;
    ext_ack_o = 7'h00;
  end
  // ack follows the request one cycle later
  always @(posedge clk_i) begin
    t0_ack_o <= ack_en_i & irq_i[1];
    t1_ack_o <= ack_en_i & irq_i[3];
    ext_ack_o <= ack_en_i ? {irq_i[8:4], irq_i[2], irq_i[0]} : 7'h00;
  end
endmodule
`default_nettype wire

// file: verif/mief_top_bench.sv
// self-checking bench of the interrupt flag block
`default_nettype none
`include "mief_map.svh"
module mief_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [15:0] idx;
    logic [7:0]  wd;
    logic [7:0]  exp;
  } mief_row_s;
  // sources packed: col a/b, lock, xfer, tick, wake, button, eeprom, engine, dio hi/lo, t0, t1, ser
  localparam logic [13:0] IDLE = 14'h0698;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        ack_en = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [13:0] stim = IDLE;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [9:0]  irq;
  logic        t0a;
  logic        t1a;
  logic [6:0]  exta;
  int          num_errors = 0;
  int          num_checks = 0;
  logic [15:0] regs [9] = '{`MIEF_IDX_TIMER_AND_EXT_CONTROL, `MIEF_IDX_INTERRUPT_ENABLE_0, `MIEF_IDX_INTERRUPT_ENABLE_1, `MIEF_IDX_EXT_EDGE_REQUEST,
    `MIEF_IDX_FLAGS, `MIEF_IDX_XT_EN, `MIEF_IDX_CL_EN, `MIEF_IDX_INTERRUPT_ENABLE_2, `MIEF_IDX_TIMER2_POLARITY_CONTROL};
  mief_row_s   rows [8] = '{
    '{`MIEF_IDX_INTERRUPT_ENABLE_1, 8'h3e, 8'h3e},
    '{`MIEF_IDX_INTERRUPT_ENABLE_2, 8'h01, 8'h01},
    '{`MIEF_IDX_TIMER2_POLARITY_CONTROL, 8'h60, 8'h60},
    '{`MIEF_IDX_TIMER2_POLARITY_CONTROL, 8'h00, 8'h00},
    '{`MIEF_IDX_XT_EN, 8'h03, 8'h03},
    '{`MIEF_IDX_CL_EN, 8'h70, 8'h70},
    '{16'h0100, 8'hff, 8'h00},
    '{`MIEF_IDX_INTERRUPT_ENABLE_0, 8'h8f, 8'h8f}};

  always #4 clk = ~clk;

  mief_top dut (.CLK_I(clk), .ARST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'b010), .HWDATA_I(hwdata),
    .HREADY_I(hreadyout), .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(),
    .TIMER0_OVERFLOW_I(stim[11]), .TIMER1_OVERFLOW_I(stim[12]), .TIMER0_VECTOR_ACK_I(t0a),
    .TIMER1_VECTOR_ACK_I(t1a), .EXT_VECTOR_ACK_I(exta), .SERIAL1_REQ_I(stim[13]),
    .DIO_HIGH_PRIO_I(stim[9]), .DIO_LOW_PRIO_I(stim[10]), .FLASH_COLLISION_A_I(stim[0]),
    .FLASH_COLLISION_B_I(stim[1]), .ENGINE_BUSY_I(stim[8]), .LOCK_OK_I(stim[2]),
    .EEPROM_BUSY_I(stim[7]), .ENGINE_TRANSFER_EVENT_I(stim[3]), .SECONDS_TICK_I(stim[4]),
    .TIMED_WAKE_I(stim[5]), .PUSH_BUTTON_I(stim[6]), .IRQ_REQ_O(irq));

  mief_core_model core (.clk_i(clk), .ack_en_i(ack_en), .irq_i(irq), .t0_ack_o(t0a),
    .t1_ack_o(t1a), .ext_ack_o(exta));

  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // address phase held until ready, then data phase held until ready
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                     input logic [7:0] exp);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {14'h0000, idx, 2'b00};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    if (!wr) check({2'b00, hrdata[7:0]}, {2'b00, exp});
    // upper read lanes always zero
    if (!wr) check({9'h000, hrdata[31:8] != 24'h000000}, 10'h000);
  endtask

  task automatic pulse(input logic [13:0] v);
    @(posedge clk);
    stim <= v;
    @(posedge clk);
    stim <= IDLE;
  endtask

  // let the core vector to everything pending except serial 1, then stop it again
  task automatic serve;
    ack_en <= 1'b1;
    repeat (3) @(posedge clk);
    check(irq, 10'h000);
    ack_en <= 1'b0;
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #50us;
    num_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    stop_test();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    foreach (regs[i]) bus(1'b0, regs[i], 8'h00, 8'h00);
    $display("test reset values done");
    foreach (rows[i]) begin
      bus(1'b1, rows[i].idx, rows[i].wd, 8'h00);
      bus(1'b0, rows[i].idx, 8'h00, rows[i].exp);
    end
    $display("test register access done");
    pulse(IDLE | 14'h1800);
    bus(1'b0, `MIEF_IDX_TIMER_AND_EXT_CONTROL, 8'h00, 8'ha0);
    check(irq, 10'h00a);
    serve();
    bus(1'b0, `MIEF_IDX_TIMER_AND_EXT_CONTROL, 8'h00, 8'h00);
    $display("test timer flags done");
    bus(1'b1, `MIEF_IDX_TIMER_AND_EXT_CONTROL, 8'h05, 8'h00);
    pulse(14'h0098);
    bus(1'b0, `MIEF_IDX_TIMER_AND_EXT_CONTROL, 8'h00, 8'h0f);
    check(irq, 10'h005);
    serve();
    bus(1'b0, `MIEF_IDX_TIMER_AND_EXT_CONTROL, 8'h00, 8'h05);
    $display("test ext0 ext1 done");
    pulse(IDLE | 14'h2000);
    // request registered at the edge that ends the pulse, seen one edge on
    @(posedge clk);
    check(irq, 10'h200);
    stim <= IDLE | 14'h2000;
    bus(1'b1, `MIEF_IDX_INTERRUPT_ENABLE_2, 8'h00, 8'h00);
    repeat (2) @(posedge clk);
    check(irq, 10'h000);
    stim <= IDLE;
    $display("test serial gate done");
    pulse(14'h0767);
    bus(1'b0, `MIEF_IDX_FLAGS, 8'h00, 8'hff);
    bus(1'b0, `MIEF_IDX_EXT_EDGE_REQUEST, 8'h00, 8'h1c);
    check(irq, 10'h0e0);
    bus(1'b1, `MIEF_IDX_FLAGS, 8'hff, 8'h00);
    bus(1'b0, `MIEF_IDX_FLAGS, 8'h00, 8'hff);
    bus(1'b1, `MIEF_IDX_FLAGS, 8'hfe, 8'h00);
    // tick flag still holds the int6 line up
    bus(1'b0, `MIEF_IDX_EXT_EDGE_REQUEST, 8'h00, 8'h1c);
    bus(1'b1, `MIEF_IDX_FLAGS, 8'hfd, 8'h00);
    bus(1'b0, `MIEF_IDX_FLAGS, 8'h00, 8'hfc);
    bus(1'b0, `MIEF_IDX_EXT_EDGE_REQUEST, 8'h00, 8'h3c);
    bus(1'b1, `MIEF_IDX_FLAGS, 8'h00, 8'h00);
    bus(1'b0, `MIEF_IDX_EXT_EDGE_REQUEST, 8'h00, 8'h3e);
    serve();
    bus(1'b0, `MIEF_IDX_EXT_EDGE_REQUEST, 8'h00, 8'h00);
    bus(1'b0, `MIEF_IDX_FLAGS, 8'h00, 8'h00);
    $display("test sub-source flags done");
    stop_test();
  end
endmodule
`default_nettype wire
